// [pucr_top.sv]
// Purpose: control and region-select logic of a memory protection unit, with access check
// Assumes: core signals are synchronous to clk; one access checked per cycle
`timescale 1ns/1ps
`default_nettype none
`include "pucr_consts.svh"
module pucr_top (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_secure,
	output logic [31:0]      reg_rdata,
	input  wire logic        acc_valid,
	input  wire logic [31:0] acc_addr,
	input  wire logic        acc_write,
	input  wire logic        acc_fetch,
	input  wire logic        acc_priv,
	input  wire logic        acc_secure,
	input  wire logic        acc_high_pri,
	output logic             memory_management_fault,
	output logic             acc_allow,
	output logic             execute_never_rule,
	output logic             strict_device_memory_type
);
	localparam logic HAS_REGIONS = (`PUCR_NUM_REGIONS != 0);

	// bank 0 nonsecure, bank 1 secure
	logic [2:0] ctrl_q [0:1];
	logic [7:0] rsel_q [0:1];
	logic [31:0] rdata_q;
	logic        fault_q;
	logic        allow_q;
	logic        xn_q;
	logic        strict_q;
	logic [7:0]  last_fault_q;

	function automatic logic is_alias(input logic [7:0] a);
		is_alias = (a >= `PUCR_OFS_BASE_A1) && (a <= `PUCR_OFS_LIMIT_A3);
	endfunction : is_alias

	function automatic logic [2:0] region_index(input logic [7:0] a, input logic [7:0] rsel);
		logic [1:0] n;
		n = 2'((a - `PUCR_OFS_BASE_A1) >> 3) + 2'h1;
		region_index = is_alias(a) ? {rsel[2], n} : rsel[2:0];
	endfunction : region_index

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	pucr_pkg::pucr_bus_t bus_op;
	always_comb begin
		if (reg_wr)
			bus_op = pucr_pkg::PUCR_BUS_WRITE;
		else if (reg_rd)
			bus_op = pucr_pkg::PUCR_BUS_READ;
		else
			bus_op = pucr_pkg::PUCR_BUS_IDLE;
	end

	logic bank;
	logic [2:0] ridx;
	logic is_region_acc;
	logic is_limit;
	assign bank          = reg_secure;
	assign ridx          = region_index(reg_addr, rsel_q[bank]);
	assign is_region_acc = HAS_REGIONS && ((reg_addr == `PUCR_OFS_BASE) || (reg_addr == `PUCR_OFS_LIMIT)
				|| is_alias(reg_addr));
	assign is_limit      = reg_addr[2];

	// control registers, banked
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q[0] <= `PUCR_CTRL_RESET;
			ctrl_q[1] <= `PUCR_CTRL_RESET;
		end else if (ce && bus_op == pucr_pkg::PUCR_BUS_WRITE && reg_addr == `PUCR_OFS_CTRL) begin
			ctrl_q[bank] <= reg_wdata[2:0];
		end
	end

	// region select, banked; field unused without regions
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsel_q[0] <= `PUCR_RSEL_RESET;
			rsel_q[1] <= `PUCR_RSEL_RESET;
		end else if (ce && HAS_REGIONS && bus_op == pucr_pkg::PUCR_BUS_WRITE && reg_addr == `PUCR_OFS_RSEL) begin
			rsel_q[bank] <= reg_wdata[7:0];
		end
	end

	logic [`PUCR_NUM_REGIONS*32-1:0] base_s, limit_s, base_ns, limit_ns;
	pucr_regfile u_regs (
		.clk       (clk),
		.ce        (ce),
		.wr_en     (bus_op == pucr_pkg::PUCR_BUS_WRITE && is_region_acc),
		.wr_secure (bank),
		.wr_limit  (is_limit),
		.wr_idx    (ridx),
		.wr_data   (reg_wdata),
		.base_s    (base_s),
		.limit_s   (limit_s),
		.base_ns   (base_ns),
		.limit_ns  (limit_ns)
	);

	// read mux, data one cycle after the strobe
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (reg_addr)
			`PUCR_OFS_CTRL:   rd_mux = {29'h0, ctrl_q[bank]};
			`PUCR_OFS_RSEL:   rd_mux = {24'h0, rsel_q[bank]};
			`PUCR_OFS_STATUS: rd_mux = {24'h0, last_fault_q};
			default: begin
				if (is_region_acc) begin
					if (bank)
						rd_mux = is_limit ? limit_s[ridx*32 +: 32] : base_s[ridx*32 +: 32];
					else
						rd_mux = is_limit ? limit_ns[ridx*32 +: 32] : base_ns[ridx*32 +: 32];
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			rdata_q <= 32'h0;
		else if (ce)
			rdata_q <= (bus_op == pucr_pkg::PUCR_BUS_READ) ? rd_mux : 32'h0;
	end
	assign reg_rdata = rdata_q;

	// access check
	logic [2:0] actl;
	logic en, hfnmi, privdef;
	assign actl    = ctrl_q[acc_secure];
	assign en      = actl[`PUCR_BIT_ENABLE];
	assign hfnmi   = actl[`PUCR_BIT_HFNMI];
	assign privdef = actl[`PUCR_BIT_PRIVDEF];

	logic any_en, hit_one, hit_many, hit_xn;
	logic [1:0] hit_ap;
	pucr_region_check u_chk (
		.addr        (acc_addr),
		.base_flat   (acc_secure ? base_s : base_ns),
		.limit_flat  (acc_secure ? limit_s : limit_ns),
		.any_enabled (any_en),
		.hit_one     (hit_one),
		.hit_many    (hit_many),
		.hit_ap      (hit_ap),
		.hit_xn      (hit_xn)
	);

	logic in_scs, in_vtab, active, region_ok, deny;
	assign in_scs  = in_range(acc_addr, `PUCR_SCS_BASE, `PUCR_SCS_LAST);
	assign in_vtab = in_range(acc_addr, `PUCR_VTAB_BASE, `PUCR_VTAB_LAST);
	// enable clear ignores background bit entirely
	assign active  = en && (!acc_high_pri || hfnmi);
	// ap: bit1 read-only, bit0 unprivileged allowed
	assign region_ok = (acc_priv || hit_ap[0]) && !(acc_write && hit_ap[1]) && !(acc_fetch && hit_xn);
	always_comb begin
		if (!active)
			deny = 1'b0;
		else if (in_scs || in_vtab)
			deny = 1'b0;
		else if (hit_many)
			deny = 1'b1;
		else if (hit_one)
			deny = !region_ok;
		else
			deny = !(privdef && acc_priv);
	end

	// scs attributes forced regardless of enable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fault_q  <= 1'b0;
			allow_q  <= 1'b0;
			xn_q     <= 1'b0;
			strict_q <= 1'b0;
		end else if (ce) begin
			fault_q  <= acc_valid && deny;
			allow_q  <= acc_valid && !deny;
			xn_q     <= acc_valid && in_scs;
			strict_q <= acc_valid && in_scs;
		end
	end
	assign memory_management_fault   = fault_q;
	assign acc_allow                 = allow_q;
	assign execute_never_rule        = xn_q;
	assign strict_device_memory_type = strict_q;

	// low address byte of last fault, a debug aid only
	always_ff @(posedge clk) begin
		if (sys_rst)
			last_fault_q <= 8'h00;
		else if (ce && acc_valid && deny)
			last_fault_q <= acc_addr[7:0];
	end

	AST_RESET_CLEARS: assert property (@(posedge clk) sys_rst |=> ctrl_q[0] == 3'h0 && ctrl_q[1] == 3'h0)
		else $error("control not cleared by reset");
	AST_DISABLED_NO_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
		ce && acc_valid && !en |=> !memory_management_fault)
		else $error("fault while protection disabled");
	AST_BYPASS_HIGH_PRI: assert property (@(posedge clk) disable iff (sys_rst)
		ce && acc_valid && acc_high_pri && !hfnmi |=> acc_allow)
		else $error("high priority handler not bypassed");
	AST_SCS_ALLOWED: assert property (@(posedge clk) disable iff (sys_rst)
		ce && acc_valid && in_scs |=> acc_allow && execute_never_rule && strict_device_memory_type)
		else $error("control area access mishandled");
	AST_MISS_FAULTS: assert property (@(posedge clk) disable iff (sys_rst)
		ce && acc_valid && active && !privdef && !hit_one && !hit_many && !in_scs && !in_vtab
		|=> memory_management_fault)
		else $error("miss without background did not fault");
	AST_UNPRIV_BG_FAULTS: assert property (@(posedge clk) disable iff (sys_rst)
		ce && acc_valid && active && !any_en && !acc_priv && !in_scs && !in_vtab |=> memory_management_fault)
		else $error("unprivileged access allowed with no region");
	AST_PRIV_BG_OK: assert property (@(posedge clk) disable iff (sys_rst)
		ce && acc_valid && active && privdef && acc_priv && !hit_one && !hit_many |=> acc_allow)
		else $error("privileged background access refused");
	AST_OVERLAP_FAULTS: assert property (@(posedge clk) disable iff (sys_rst)
		ce && acc_valid && active && hit_many && !in_scs && !in_vtab |=> memory_management_fault)
		else $error("overlap hit did not fault");
	AST_CTRL_READ_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		ce && reg_rd && reg_addr == `PUCR_OFS_CTRL |=> reg_rdata[31:3] == 29'h0)
		else $error("control reserved bits nonzero");
	AST_BANK_ISOLATED: assert property (@(posedge clk) disable iff (sys_rst)
		ce && reg_wr && reg_addr == `PUCR_OFS_CTRL && !reg_secure |=> $stable(ctrl_q[1]))
		else $error("nonsecure write touched secure copy");
endmodule : pucr_top
`default_nettype wire

// [pucr_consts.svh]
// Purpose: constants for the protection unit control and region-select block
// Assumes: 32-bit register port, word offsets chosen for this block
// Notes:   included by the top, region check, register file and bench
`ifndef PUCR_CONSTS_SVH
`define PUCR_CONSTS_SVH

`define PUCR_OFS_CTRL       8'h00
`define PUCR_OFS_RSEL       8'h04
`define PUCR_OFS_BASE       8'h08
`define PUCR_OFS_LIMIT      8'h0C
`define PUCR_OFS_BASE_A1    8'h10
`define PUCR_OFS_LIMIT_A1   8'h14
`define PUCR_OFS_BASE_A2    8'h18
`define PUCR_OFS_LIMIT_A2   8'h1C
`define PUCR_OFS_BASE_A3    8'h20
`define PUCR_OFS_LIMIT_A3   8'h24
`define PUCR_OFS_STATUS     8'h28
`define PUCR_BIT_ENABLE     0
`define PUCR_BIT_HFNMI      1
`define PUCR_BIT_PRIVDEF    2
`define PUCR_CTRL_RESET     3'h0
`define PUCR_RSEL_RESET     8'h00
`define PUCR_NUM_REGIONS    8
`define PUCR_LIMIT_EN_BIT   0
`define PUCR_SCS_BASE       32'hE000E000
`define PUCR_SCS_LAST       32'hE000EFFF
`define PUCR_VTAB_BASE      32'h00000000
`define PUCR_VTAB_LAST      32'h000003FF

`endif

// [pucr_pkg.sv]
// Purpose: types for the protection unit control and region-select block
// Assumes: nothing
// Notes:   constants live in pucr_consts.svh
package pucr_pkg;
	typedef enum logic [2:0] {
		PUCR_BUS_IDLE  = 3'b001,
		PUCR_BUS_WRITE = 3'b010,
		PUCR_BUS_READ  = 3'b100
	} pucr_bus_t;
	typedef logic [1:0] pucr_bank_t;
endpackage : pucr_pkg

// [pucr_region_check.sv]
// Purpose: region match for one access against the region table of one bank
// Assumes: base and limit words as laid out in the region registers
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "pucr_consts.svh"
module pucr_region_check (
	input  wire logic [31:0] addr,
	input  wire logic [`PUCR_NUM_REGIONS*32-1:0] base_flat,
	input  wire logic [`PUCR_NUM_REGIONS*32-1:0] limit_flat,
	output logic             any_enabled,
	output logic             hit_one,
	output logic             hit_many,
	output logic [1:0]       hit_ap,
	output logic             hit_xn
);
	function automatic logic in_region(input logic [31:0] a, input logic [31:0] b, input logic [31:0] l);
		in_region = l[`PUCR_LIMIT_EN_BIT] && (a >= {b[31:5], 5'h00}) && (a <= {l[31:5], 5'h1F});
	endfunction : in_region

	logic [3:0] hits;
	always_comb begin
		hits        = 4'h0;
		any_enabled = 1'b0;
		hit_ap      = 2'h0;
		hit_xn      = 1'b0;
		for (int i = 0; i < `PUCR_NUM_REGIONS; i++) begin
			any_enabled = any_enabled | limit_flat[i*32+`PUCR_LIMIT_EN_BIT];
			if (in_region(addr, base_flat[i*32 +: 32], limit_flat[i*32 +: 32])) begin
				hits   = hits + 4'h1;
				hit_ap = base_flat[i*32+1 +: 2];
				hit_xn = base_flat[i*32];
			end
		end
		hit_one  = (hits == 4'h1);
		hit_many = (hits > 4'h1);
	end
endmodule : pucr_region_check
`default_nettype wire

// [pucr_regfile.sv]
// Purpose: banked region base and limit storage, one table per security state
// Assumes: index already resolved (alias applied) by the caller
// Notes:   no reset; contents are unknown until software writes them
`timescale 1ns/1ps
`default_nettype none
`include "pucr_consts.svh"
module pucr_regfile (
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        wr_en,
	input  wire logic        wr_secure,
	input  wire logic        wr_limit,
	input  wire logic [2:0]  wr_idx,
	input  wire logic [31:0] wr_data,
	output logic [`PUCR_NUM_REGIONS*32-1:0] base_s,
	output logic [`PUCR_NUM_REGIONS*32-1:0] limit_s,
	output logic [`PUCR_NUM_REGIONS*32-1:0] base_ns,
	output logic [`PUCR_NUM_REGIONS*32-1:0] limit_ns
);
	logic [31:0] mem_q [0:4*`PUCR_NUM_REGIONS-1];
	always_ff @(posedge clk) begin
		if (ce && wr_en)
			mem_q[{wr_secure, wr_limit, wr_idx}] <= wr_data;
	end
	always_comb begin
		for (int i = 0; i < `PUCR_NUM_REGIONS; i++) begin
			base_ns[i*32 +: 32]  = mem_q[i];
			limit_ns[i*32 +: 32] = mem_q[i+8];
			base_s[i*32 +: 32]   = mem_q[i+16];
			limit_s[i*32 +: 32]  = mem_q[i+24];
		end
	end
endmodule : pucr_regfile
`default_nettype wire

// [pucr_core_model.sv]
// Purpose: core fetch and load/store path model driving the access port
// Assumes: bench requests are registered one cycle before reaching the block
// Notes:   idle address inverts on each idle cycle, so it shows the last one again every other cycle
`timescale 1ns/1ps
`default_nettype none
module pucr_core_model (
	input  wire logic        clk,
	input  wire logic        req_valid,
	input  wire logic [31:0] req_addr,
	input  wire logic        req_write,
	input  wire logic        req_fetch,
	input  wire logic        req_priv,
	input  wire logic        req_secure,
	input  wire logic        req_high,
	output logic             acc_valid,
	output logic [31:0]      acc_addr,
	output logic             acc_write,
	output logic             acc_fetch,
	output logic             acc_priv,
	output logic             acc_secure,
	output logic             acc_high_pri
);
	// outputs stay unknown until the first edge, acc_addr until the first valid request; the block is in reset at the first edge, acc_valid low after it
	always_ff @(posedge clk) begin
		acc_valid <= req_valid;
		acc_addr <= req_valid ? req_addr : ~acc_addr;
		{acc_write, acc_fetch, acc_priv, acc_secure, acc_high_pri} <=
			{req_write, req_fetch, req_priv, req_secure, req_high};
	end
endmodule : pucr_core_model
`default_nettype wire

// [pucr_top_tb_top.sv]
// Purpose: self-checking bench for the protection control and region-select block
// Assumes: regions 0 and 1 of the nonsecure bank cover a test window
// Notes:   random control values never set handler enforcement with enable clear
`timescale 1ns/1ps
`default_nettype none
`include "pucr_consts.svh"
module pucr_top_tb_top;
	logic clk, sys_rst, ce, reg_wr, reg_rd, reg_secure;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, acc_addr, r_addr, seed, rv, a_pick;
	logic acc_valid, acc_write, acc_fetch, acc_priv, acc_secure, acc_high_pri;
	logic r_valid, r_write, r_fetch, r_priv, r_secure, r_high;
	logic fault, allow, xn, strict, regs_on;
	logic [2:0] ctrl_ns;
	int err_total, n_compared;
	logic [31:0] addrs [6] = '{32'hE000ED94, 32'h00000100, 32'h20000400,
		32'h20000C00, 32'h20001800, 32'h30000000};

	pucr_core_model core (.clk(clk), .req_valid(r_valid), .req_addr(r_addr), .req_write(r_write),
		.req_fetch(r_fetch), .req_priv(r_priv), .req_secure(r_secure), .req_high(r_high),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_fetch(acc_fetch),
		.acc_priv(acc_priv), .acc_secure(acc_secure), .acc_high_pri(acc_high_pri));
	pucr_top dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_secure(reg_secure), .reg_rdata(reg_rdata),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_fetch(acc_fetch),
		.acc_priv(acc_priv), .acc_secure(acc_secure), .acc_high_pri(acc_high_pri),
		.memory_management_fault(fault), .acc_allow(allow), .execute_never_rule(xn),
		.strict_device_memory_type(strict));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask : check

	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		reg_secure <= s;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic s, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		reg_secure <= s;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// fault, allow, execute-never, strict device
	function automatic logic [3:0] exp_acc(input logic [2:0] c, input logic [31:0] a,
		input logic p, input logic h);
		logic scs, ok, r0, r1;
		scs = a >= `PUCR_SCS_BASE && a <= `PUCR_SCS_LAST;
		r0 = regs_on && a >= 32'h20000000 && a <= 32'h20000FFF;
		r1 = regs_on && a >= 32'h20000800 && a <= 32'h20001FFF;
		if (!c[0] || (h && !c[1]) || scs || a <= `PUCR_VTAB_LAST)
			ok = 1'b1;
		else if (r0 && r1)
			ok = 1'b0;
		else
			ok = r0 || r1 || (c[2] && p);
		return {!ok, ok, scs, scs};
	endfunction : exp_acc

	task automatic acc(input logic [31:0] a, input logic p, input logic h, input logic s, input logic f);
		@(posedge clk);
		{r_valid, r_addr, r_priv, r_high, r_secure, r_fetch, r_write} <= {1'b1, a, p, h, s, f, ~f & p};
		@(posedge clk);
		r_valid <= 1'b0;
		@(posedge clk);
		#1 check("access", {fault, allow, xn, strict}, exp_acc(s ? 3'h0 : ctrl_ns, a, p, h));
	endtask : acc

	initial begin
		seed = 32'h3813;
		{sys_rst, reg_wr, reg_rd, reg_secure, r_valid, r_write, r_fetch, r_priv, r_secure, r_high} = 10'h200;
		{reg_addr, reg_wdata, r_addr} = '0;
		ce = 1'b1;
		err_total = 0;
		n_compared = 0;
		regs_on = 1'b0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`PUCR_OFS_CTRL, 1'b0, rv); check("ctrl ns", rv, 32'h0);
		rd(`PUCR_OFS_CTRL, 1'b1, rv); check("ctrl s", rv, 32'h0);
		wr(`PUCR_OFS_CTRL, 32'hFFFFFFFD, 1'b0);
		rd(`PUCR_OFS_CTRL, 1'b0, rv); check("ctrl ns", rv, 32'h5);
		@(posedge clk);
		#1 check("rdata idle", reg_rdata, 32'h0);
		// a write strobe while the clock enable is low must leave the control copy alone
		ce <= 1'b0;
		wr(`PUCR_OFS_CTRL, 32'h0, 1'b0);
		ce <= 1'b1;
		rd(`PUCR_OFS_CTRL, 1'b0, rv); check("ctrl frozen", rv, 32'h5);
		rd(`PUCR_OFS_CTRL, 1'b1, rv); check("ctrl s", rv, 32'h0);
		wr(`PUCR_OFS_RSEL, 32'hFFFFFF03, 1'b0);
		rd(`PUCR_OFS_RSEL, 1'b0, rv); check("rsel", rv, 32'h3);
		rd(`PUCR_OFS_RSEL, 1'b1, rv); check("rsel s", rv, 32'h0);
		rd(8'h3C, 1'b0, rv); check("unmapped", rv, 32'h0);
		// alias 1 over select 4 must land in region 5
		wr(`PUCR_OFS_RSEL, 32'h4, 1'b0);
		wr(`PUCR_OFS_BASE, 32'h11111100, 1'b0);
		wr(`PUCR_OFS_BASE_A1, 32'h22222200, 1'b0);
		rd(`PUCR_OFS_BASE, 1'b0, rv); check("base 4", rv, 32'h11111100);
		wr(`PUCR_OFS_RSEL, 32'h5, 1'b0);
		rd(`PUCR_OFS_BASE, 1'b0, rv); check("base 5", rv, 32'h22222200);
		// region storage has no reset, so every enable is cleared first
		for (int b = 0; b < 2; b++)
			for (int i = 0; i < `PUCR_NUM_REGIONS; i++) begin
				wr(`PUCR_OFS_RSEL, 32'(i), b[0]);
				wr(`PUCR_OFS_LIMIT, 32'h0, b[0]);
			end
		wr(`PUCR_OFS_CTRL, 32'h0, 1'b1);
		wr(`PUCR_OFS_RSEL, 32'h0, 1'b0);
		wr(`PUCR_OFS_BASE, 32'h20000002, 1'b0);
		wr(`PUCR_OFS_LIMIT, 32'h20000FE1, 1'b0);
		wr(`PUCR_OFS_BASE_A1, 32'h20000802, 1'b0);
		wr(`PUCR_OFS_LIMIT_A1, 32'h20001FE1, 1'b0);
		regs_on = 1'b1;
		repeat (120) begin
			rv = $random(seed);
			ctrl_ns = rv[2:0];
			if (!ctrl_ns[0])
				ctrl_ns[1] = 1'b0;
			wr(`PUCR_OFS_CTRL, {29'h0, ctrl_ns}, 1'b0);
			a_pick = addrs[rv[10:8] % 6] + {26'h0, rv[15:12], 2'h0};
			acc(a_pick, rv[16], rv[17], rv[18], rv[19] && a_pick < `PUCR_SCS_BASE);
		end
		// background only, no region enabled
		wr(`PUCR_OFS_LIMIT, 32'h0, 1'b0);
		wr(`PUCR_OFS_LIMIT_A1, 32'h0, 1'b0);
		regs_on = 1'b0;
		ctrl_ns = 3'h5;
		wr(`PUCR_OFS_CTRL, 32'h5, 1'b0);
		acc(32'h20000400, 1'b1, 1'b0, 1'b0, 1'b0);
		acc(32'h200004A8, 1'b0, 1'b0, 1'b0, 1'b0);
		rd(`PUCR_OFS_STATUS, 1'b0, rv); check("fault addr", rv, 32'hA8);
		summarize();
	end

	initial begin
		#200000;
		err_total++;
		summarize();
	end
endmodule : pucr_top_tb_top
`default_nettype wire
